// [common/lane_map_pkg.sv]
`default_nettype none
package lane_map_pkg;
  // link mode codes
  localparam logic [7:0] MODE_27 = 8'd27;
  localparam logic [7:0] MODE_32 = 8'd32;
  localparam logic [7:0] MODE_33 = 8'd33;
  localparam logic [7:0] MODE_34 = 8'd34;
  localparam logic [7:0] MODE_35 = 8'd35;
  localparam logic [7:0] MODE_37 = 8'd37;
  localparam logic [7:0] MODE_38 = 8'd38;
  localparam logic [7:0] MODE_39 = 8'd39;
  localparam logic [7:0] MODE_56 = 8'd56;
  localparam logic [7:0] MODE_RST = MODE_38;
  // lane enable masks, lanes A0..A7 are bits 0..7, B0..B7 bits 8..15
  localparam logic [15:0] LANES_16 = 16'hffff;
  localparam logic [15:0] LANES_6  = 16'h0707;
  localparam logic [15:0] LANES_4  = 16'h0303;
  localparam logic [15:0] LANES_2  = 16'h0101;
  localparam logic [15:0] LANES_A  = 16'h00ff;
  localparam logic [15:0] LANES_B  = 16'hff00;
  localparam int          LANE_B0  = 8;
  // serializer test pattern codes
  localparam logic [3:0]  TP_DATA  = 4'h0;
  localparam logic [3:0]  TP_CLOCK = 4'h1;
  localparam logic [3:0]  TP_RAMP  = 4'h2;
  localparam logic [31:0] CLOCK_PAT = 32'hff00ff00;
  // crc-12 polynomial x^12+x^11+x^3+x^2+x+1
  localparam logic [11:0] CRC12_POLY = 12'h80f;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CAL    = 8'h04;
  localparam logic [7:0] OFS_MODE   = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0c;
  localparam logic [7:0] OFS_MASK   = 8'h10;
  localparam logic [7:0] OFS_RXA0   = 8'h14;
  localparam logic [7:0] OFS_RXB0   = 8'h18;
  localparam logic [7:0] OFS_CRC    = 8'h1c;
  // control fields
  localparam int CTRL_LINK_EN = 0;
  localparam int CTRL_FEC     = 1;
  localparam int CTRL_MODE_PD = 2;
  localparam int CTRL_PD_PIN  = 3;
  localparam int CTRL_CHPD_LO = 4;
  localparam int MODE_TP_LO   = 8;
  localparam int CRC_FEC_BIT  = 16;
  localparam logic [1:0] CAL_OFF_RST = 2'h1;
  // status events
  localparam int EV_FRAME   = 0;
  localparam int EV_FLUSHED = 1;
  localparam int EV_REFUSED = 2;
  localparam int EV_W       = 3;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // pipeline flush wait after power-down
  localparam int CLK_MHZ    = 100;
  localparam int FLUSH_NS   = 1000;
  localparam int FLUSH_CYC  = FLUSH_NS * CLK_MHZ / 1000;
  localparam logic [11:0] FLUSH_LOAD = 12'(FLUSH_CYC);
endpackage : lane_map_pkg
`default_nettype wire

// [common/lane_map_if.sv]
`default_nettype none
interface lane_map_if;
  // configuration from the controller
  logic             link_en;
  logic             fec_sel;
  logic             mode_pd;
  logic             power_down_pin;
  logic [1:0]       chan_pd;
  logic [1:0]       converter_off;
  logic [7:0]       link_mode_select;
  logic [3:0]       test_pattern_select;
  // lanes and sync header from the device
  logic [15:0][31:0] lane_data;
  logic [15:0]       lane_oe;
  logic              frame_strobe;
  logic [11:0]       sync_crc;
  logic              sync_fec;
  modport dev (input link_en, fec_sel, mode_pd, power_down_pin, chan_pd, converter_off,
               link_mode_select, test_pattern_select,
               output lane_data, lane_oe, frame_strobe, sync_crc, sync_fec);
  modport host (output link_en, fec_sel, mode_pd, power_down_pin, chan_pd, converter_off,
                link_mode_select, test_pattern_select,
                input lane_data, lane_oe, frame_strobe, sync_crc, sync_fec);
endinterface : lane_map_if
`default_nettype wire

// [core/lane_mapper.sv]
`default_nettype none
module lane_mapper (
  // clock and reset
  input  wire logic             MCLK,
  input  wire logic             RST_B,
  // converter samples: A = channel A / in-phase / even, B = channel B / quadrature / odd
  input  wire logic [7:0][14:0] SMP_A,
  input  wire logic [7:0][14:0] SMP_B,
  input  wire logic [7:0]       FLG_A,
  input  wire logic [7:0]       FLG_B,
  input  wire logic             SMP_VALID,
  // serial link side
  lane_map_if.dev               LINK
);
  logic             pd_meta_reg, pd_s1_reg, pd_s2_reg, pd_pin_reg;
  logic [15:0][31:0] lane_reg, lane_next;
  logic [15:0]       oe_reg, oe_next, mode_mask;
  logic              strobe_reg, strobe_next;
  logic [11:0]       crc_reg;
  logic              fec_reg;
  logic [7:0]        ramp_reg;
  logic              dual, pd_all;
  logic [47:0]       pack_a, pack_b;

  // packed lane word: sample msb first, flag in bit zero
  function automatic logic [15:0] w16(input logic [14:0] s, input logic f);
    w16 = {s, f};
  endfunction : w16

  // serial crc-12 over one 32-bit lane word
  function automatic logic [11:0] crc12(input logic [11:0] c, input logic [31:0] d);
    logic [11:0] r;
    r = c;
    for (int i = 31; i >= 0; i--) begin
      r = (r[11] ^ d[i]) ? ((r << 1) ^ lane_map_pkg::CRC12_POLY) : (r << 1);
    end
    crc12 = r;
  endfunction : crc12

  // power-down pin is asynchronous: three stages, change taken when last two agree
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      pd_meta_reg <= 1'b0;
      pd_s1_reg   <= 1'b0;
      pd_s2_reg   <= 1'b0;
      pd_pin_reg  <= 1'b0;
    end else begin
      pd_meta_reg <= LINK.power_down_pin;
      pd_s1_reg   <= pd_meta_reg;
      pd_s2_reg   <= pd_s1_reg;
      if (pd_s1_reg == pd_s2_reg) pd_pin_reg <= pd_s2_reg;
    end
  end

  // the config bit acts at once; the pin waits out its synchroniser first
  // config power-down joins the pin
  assign pd_all = pd_pin_reg | LINK.mode_pd;

  // 12-bit samples, msb first, contiguous over three lanes per group
  assign pack_a = {SMP_A[0][14:3], SMP_A[1][14:3], SMP_A[2][14:3], SMP_A[3][14:3]};
  assign pack_b = {SMP_B[0][14:3], SMP_B[1][14:3], SMP_B[2][14:3], SMP_B[3][14:3]};

  // lanes in use and dual-channel flag per mode
  always_comb begin
    mode_mask = 16'h0000;
    dual      = 1'b0;
    case (LINK.link_mode_select)
      lane_map_pkg::MODE_27: mode_mask = lane_map_pkg::LANES_16;
      lane_map_pkg::MODE_32: mode_mask = lane_map_pkg::LANES_6;
      lane_map_pkg::MODE_33: begin
        mode_mask = lane_map_pkg::LANES_6;
        dual      = 1'b1;
      end
      lane_map_pkg::MODE_34: mode_mask = lane_map_pkg::LANES_4;
      lane_map_pkg::MODE_35, lane_map_pkg::MODE_37: begin
        mode_mask = lane_map_pkg::LANES_4;
        dual      = 1'b1;
      end
      lane_map_pkg::MODE_38: mode_mask = lane_map_pkg::LANES_2;
      lane_map_pkg::MODE_39, lane_map_pkg::MODE_56: begin
        mode_mask = lane_map_pkg::LANES_2;
        dual      = 1'b1;
      end
      default: mode_mask = 16'h0000;
    endcase
  end

  // sample to lane mapping; unused octets and lanes carry zero
  always_comb begin
    lane_next = '0;
    case (LINK.link_mode_select)
      lane_map_pkg::MODE_27: begin
        for (int k = 0; k < 8; k++) begin
          lane_next[k]                       = {w16(SMP_A[k], FLG_A[k]), 16'h0000};
          lane_next[lane_map_pkg::LANE_B0+k] = {w16(SMP_B[k], FLG_B[k]), 16'h0000};
        end
      end
      // even on A, odd on B
      lane_map_pkg::MODE_32, lane_map_pkg::MODE_33: begin
        for (int k = 0; k < 3; k++) begin
          lane_next[k]                       = {pack_a[47-16*k -: 16], 16'h0000};
          lane_next[lane_map_pkg::LANE_B0+k] = {pack_b[47-16*k -: 16], 16'h0000};
        end
      end
      lane_map_pkg::MODE_34, lane_map_pkg::MODE_35: begin
        lane_next[0]                       = {SMP_A[0][14:7], 24'h000000};
        lane_next[1]                       = {SMP_A[1][14:7], 24'h000000};
        lane_next[lane_map_pkg::LANE_B0]   = {SMP_B[0][14:7], 24'h000000};
        lane_next[lane_map_pkg::LANE_B0+1] = {SMP_B[1][14:7], 24'h000000};
      end
      // i and q on own lanes
      lane_map_pkg::MODE_37: begin
        lane_next[0]                       = {w16(SMP_A[0], FLG_A[0]), 16'h0000};
        lane_next[1]                       = {w16(SMP_A[1], FLG_A[1]), 16'h0000};
        lane_next[lane_map_pkg::LANE_B0]   = {w16(SMP_B[0], FLG_B[0]), 16'h0000};
        lane_next[lane_map_pkg::LANE_B0+1] = {w16(SMP_B[1], FLG_B[1]), 16'h0000};
      end
      lane_map_pkg::MODE_38: begin
        lane_next[0]                     = {w16(SMP_A[0], FLG_A[0]), 16'h0000};
        lane_next[lane_map_pkg::LANE_B0] = {w16(SMP_B[0], FLG_B[0]), 16'h0000};
      end
      lane_map_pkg::MODE_39, lane_map_pkg::MODE_56: begin
        lane_next[0]                     = {w16(SMP_A[0], FLG_A[0]), w16(SMP_A[1], FLG_A[1])};
        lane_next[lane_map_pkg::LANE_B0] = {w16(SMP_B[0], FLG_B[0]), w16(SMP_B[1], FLG_B[1])};
      end
      default: lane_next = '0;
    endcase
    case (LINK.test_pattern_select)
      lane_map_pkg::TP_CLOCK: lane_next = {16{lane_map_pkg::CLOCK_PAT}};
      lane_map_pkg::TP_RAMP:  lane_next = {16{ramp_reg, 8'(ramp_reg + 8'h01), 8'(ramp_reg + 8'h02),
                                              8'(ramp_reg + 8'h03)}};
      default: ;
    endcase
  end

  // drivers follow the mode whatever the test; power-down shuts them all
  always_comb begin
    oe_next = mode_mask;
    // one channel off in dual mode
    if (dual && LINK.chan_pd[0]) oe_next = oe_next & lane_map_pkg::LANES_B;
    if (dual && LINK.chan_pd[1]) oe_next = oe_next & lane_map_pkg::LANES_A;
    if (pd_all) oe_next = 16'h0000;
    strobe_next = LINK.link_en && !pd_all &&
                  (SMP_VALID || LINK.test_pattern_select != lane_map_pkg::TP_DATA);
  end

  // lane registers; disabled lanes are held at zero
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      lane_reg   <= '0;
      oe_reg     <= 16'h0000;
      strobe_reg <= 1'b0;
    end else begin
      oe_reg     <= oe_next;
      strobe_reg <= strobe_next;
      for (int l = 0; l < 16; l++) begin
        if (!oe_next[l]) lane_reg[l] <= 32'h00000000;
        else if (strobe_next) lane_reg[l] <= lane_next[l];
      end
    end
  end

  // ramp advances one frame at a time so receivers can predict it
  // limitation: the ramp counts per frame, not across a multiframe
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      ramp_reg <= 8'h00;
    end else if (LINK.test_pattern_select != lane_map_pkg::TP_RAMP || !LINK.link_en) begin
      ramp_reg <= 8'h00;
    end else if (strobe_next) begin
      ramp_reg <= 8'(ramp_reg + 8'h04);
    end
  end

  // sync header check value over lane A0, restarted while the link is down
  // the crc keeps running on lane A0 even while channel A is powered off
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      crc_reg <= 12'h000;
      fec_reg <= 1'b0;
    end else begin
      fec_reg <= LINK.fec_sel;
      if (!LINK.link_en || LINK.fec_sel) crc_reg <= 12'h000;
      else if (strobe_next) crc_reg <= crc12(crc_reg, lane_next[0]);
    end
  end

  assign LINK.lane_data    = lane_reg;
  assign LINK.lane_oe      = oe_reg;
  assign LINK.frame_strobe = strobe_reg;
  assign LINK.sync_crc     = crc_reg;
  assign LINK.sync_fec     = fec_reg;
endmodule : lane_mapper
`default_nettype wire

// [core/link_ctrl.sv]
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`default_nettype none
module link_ctrl (
  // clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST_B,
  // axi4-lite write
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [7:0]  AWADDR,
  input  wire logic        WVALID,
  output logic             WREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic [3:0]  WSTRB,
  output logic             BVALID,
  input  wire logic        BREADY,
  output logic [1:0]       BRESP,
  // axi4-lite read
  input  wire logic        ARVALID,
  output logic             ARREADY,
  input  wire logic [7:0]  ARADDR,
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  // interrupt and received frames
  output logic             IRQ,
  output logic             RX_VALID,
  output logic [31:0]      RX_A0,
  output logic [31:0]      RX_B0,
  // link side
  lane_map_if.host         LINK
);
  logic        awr_reg, wr_reg, awfull_reg, wfull_reg, arr_reg, rv_reg, irq_reg;
  logic [1:0]  bresp_reg, rresp_reg;
  logic        bv_reg, rxv_reg, linken_reg, pd_prev_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg, rdata_reg, rxa_reg, rxb_reg;
  logic [3:0]  wstrb_reg;
  logic [31:0] ctrl_reg, cal_reg, mode_reg, mask_reg, wmerge, rd_val;
  logic [lane_map_pkg::EV_W-1:0] status_reg, ev, clr;
  logic [11:0] flush_reg;
  logic        do_wr, do_rd, hit, pd_any;

  assign do_wr  = awfull_reg && wfull_reg && !bv_reg;
  assign do_rd  = ARVALID && arr_reg;
  assign pd_any = ctrl_reg[lane_map_pkg::CTRL_PD_PIN] | ctrl_reg[lane_map_pkg::CTRL_MODE_PD];

  // address and data are taken in either order and held until the write lands
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      {awr_reg, wr_reg, awfull_reg, wfull_reg, bv_reg} <= 5'h00;
      awaddr_reg <= 8'h00;
      wdata_reg  <= 32'h00000000;
      wstrb_reg  <= 4'h0;
      bresp_reg  <= lane_map_pkg::RESP_OKAY;
    end else begin
      if (AWVALID && awr_reg) begin
        awfull_reg <= 1'b1;
        awr_reg    <= 1'b0;
        awaddr_reg <= AWADDR;
      end else if (do_wr) awfull_reg <= 1'b0;
      else if (!awfull_reg && !bv_reg) awr_reg <= 1'b1;
      if (WVALID && wr_reg) begin
        wfull_reg <= 1'b1;
        wr_reg    <= 1'b0;
        wdata_reg <= WDATA;
        wstrb_reg <= WSTRB;
      end else if (do_wr) wfull_reg <= 1'b0;
      else if (!wfull_reg && !bv_reg) wr_reg <= 1'b1;
      if (do_wr) begin
        bv_reg    <= 1'b1;
        bresp_reg <= hit ? lane_map_pkg::RESP_OKAY : lane_map_pkg::RESP_SLVERR;
      end else if (BREADY) bv_reg <= 1'b0;
    end
  end

  // byte lanes merged into the addressed register; writable map is ctrl, cal, mode, mask
  always_comb begin
    hit    = 1'b1;
    wmerge = 32'h00000000;
    if (awaddr_reg == lane_map_pkg::OFS_CTRL) wmerge = ctrl_reg;
    else if (awaddr_reg == lane_map_pkg::OFS_CAL) wmerge = cal_reg;
    else if (awaddr_reg == lane_map_pkg::OFS_MODE) wmerge = mode_reg;
    else if (awaddr_reg == lane_map_pkg::OFS_MASK) wmerge = mask_reg;
    else hit = 1'b0;
    for (int b = 0; b < 4; b++) begin
      if (wstrb_reg[b]) wmerge[8*b +: 8] = wdata_reg[8*b +: 8];
    end
  end

  // configuration registers
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      ctrl_reg <= 32'h00000000;
      cal_reg  <= {30'h0, lane_map_pkg::CAL_OFF_RST};
      mode_reg <= {24'h0, lane_map_pkg::MODE_RST};
      mask_reg <= 32'h00000000;
    end else if (do_wr) begin
      if (awaddr_reg == lane_map_pkg::OFS_CTRL) ctrl_reg <= {26'h0, wmerge[5:0]};
      else if (awaddr_reg == lane_map_pkg::OFS_CAL) cal_reg <= {30'h0, wmerge[1:0]};
      else if (awaddr_reg == lane_map_pkg::OFS_MODE) begin
        mode_reg[7:0] <= wmerge[7:0];
        // test select only while link off
        if (!ctrl_reg[lane_map_pkg::CTRL_LINK_EN]) mode_reg[11:8] <= wmerge[11:8];
      end else if (awaddr_reg == lane_map_pkg::OFS_MASK) mask_reg <= {29'h0, wmerge[2:0]};
    end
  end

  // read mux
  always_comb begin
    rd_val = 32'h00000000;
    if (ARADDR == lane_map_pkg::OFS_CTRL) rd_val = ctrl_reg;
    else if (ARADDR == lane_map_pkg::OFS_CAL) rd_val = cal_reg;
    else if (ARADDR == lane_map_pkg::OFS_MODE) rd_val = mode_reg;
    else if (ARADDR == lane_map_pkg::OFS_STATUS) rd_val = {29'h0, status_reg};
    else if (ARADDR == lane_map_pkg::OFS_MASK) rd_val = mask_reg;
    else if (ARADDR == lane_map_pkg::OFS_RXA0) rd_val = rxa_reg;
    else if (ARADDR == lane_map_pkg::OFS_RXB0) rd_val = rxb_reg;
    else if (ARADDR == lane_map_pkg::OFS_CRC) rd_val = {15'h0, LINK.sync_fec, 4'h0, LINK.sync_crc};
  end

  // one read at a time; data registered at the address handshake
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      {arr_reg, rv_reg} <= 2'b00;
      rdata_reg <= 32'h00000000;
      rresp_reg <= lane_map_pkg::RESP_OKAY;
    end else if (do_rd) begin
      arr_reg   <= 1'b0;
      rv_reg    <= 1'b1;
      rdata_reg <= rd_val;
      rresp_reg <= (ARADDR <= lane_map_pkg::OFS_CRC && ARADDR[1:0] == 2'b00) ?
                   lane_map_pkg::RESP_OKAY : lane_map_pkg::RESP_SLVERR;
    end else if (rv_reg) begin
      if (RREADY) rv_reg <= 1'b0;
    end else arr_reg <= 1'b1;
  end

  // events; a read of status clears it but a new event in that cycle survives
  always_comb begin
    ev = '0;
    ev[lane_map_pkg::EV_FRAME]   = LINK.frame_strobe && linken_reg;
    ev[lane_map_pkg::EV_FLUSHED] = (flush_reg == 12'h001);
    ev[lane_map_pkg::EV_REFUSED] = do_wr && awaddr_reg == lane_map_pkg::OFS_MODE &&
                                   ctrl_reg[lane_map_pkg::CTRL_LINK_EN] &&
                                   (wmerge[11:8] != mode_reg[11:8]);
    clr = (do_rd && ARADDR == lane_map_pkg::OFS_STATUS) ? '1 : '0;
  end

  // after power-down the link is held down and frames dropped until the pipeline drains
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      status_reg  <= '0;
      irq_reg     <= 1'b0;
      pd_prev_reg <= 1'b0;
      flush_reg   <= 12'h000;
      linken_reg  <= 1'b0;
      rxv_reg     <= 1'b0;
      rxa_reg     <= 32'h00000000;
      rxb_reg     <= 32'h00000000;
    end else begin
      status_reg  <= (status_reg & ~clr) | ev;
      irq_reg     <= |(((status_reg & ~clr) | ev) & mask_reg[lane_map_pkg::EV_W-1:0]);
      pd_prev_reg <= pd_any;
      if (pd_any) flush_reg <= 12'h000;
      else if (pd_prev_reg) flush_reg <= lane_map_pkg::FLUSH_LOAD;
      else if (flush_reg != 12'h000) flush_reg <= flush_reg - 12'h001;
      linken_reg <= ctrl_reg[lane_map_pkg::CTRL_LINK_EN] && !pd_any && !pd_prev_reg &&
                    (flush_reg == 12'h000);
      rxv_reg    <= LINK.frame_strobe && linken_reg;
      if (LINK.frame_strobe && linken_reg) begin
        rxa_reg <= LINK.lane_data[0];
        rxb_reg <= LINK.lane_data[lane_map_pkg::LANE_B0];
      end
    end
  end

  assign LINK.fec_sel             = ctrl_reg[lane_map_pkg::CTRL_FEC];
  assign LINK.link_en             = linken_reg;
  assign LINK.mode_pd             = ctrl_reg[lane_map_pkg::CTRL_MODE_PD];
  assign LINK.power_down_pin      = ctrl_reg[lane_map_pkg::CTRL_PD_PIN];
  assign LINK.chan_pd             = ctrl_reg[lane_map_pkg::CTRL_CHPD_LO +: 2];
  assign LINK.converter_off       = cal_reg[1:0];
  assign LINK.link_mode_select    = mode_reg[7:0];
  assign LINK.test_pattern_select = mode_reg[lane_map_pkg::MODE_TP_LO +: 4];
  assign AWREADY = awr_reg;
  assign WREADY  = wr_reg;
  assign BVALID  = bv_reg;
  assign BRESP   = bresp_reg;
  assign ARREADY = arr_reg;
  assign RVALID  = rv_reg;
  assign RDATA   = rdata_reg;
  assign RRESP   = rresp_reg;
  assign IRQ     = irq_reg;
  assign RX_VALID = rxv_reg;
  assign RX_A0   = rxa_reg;
  assign RX_B0   = rxb_reg;
endmodule : link_ctrl
`default_nettype wire

// [tb/lane_map_assertions.sv]
`default_nettype none
module lane_map_assertions (
  // clock and reset
  input wire logic              MCLK,
  input wire logic              RST_B,
  // link signals
  input wire logic              fec_sel,
  input wire logic              mode_pd,
  input wire logic              power_down_pin,
  input wire logic [1:0]        chan_pd,
  input wire logic [7:0]        link_mode_select,
  input wire logic [3:0]        test_pattern_select,
  input wire logic [15:0][31:0] lane_data,
  input wire logic [15:0]       lane_oe,
  input wire logic              frame_strobe,
  input wire logic [11:0]       sync_crc,
  input wire logic              sync_fec
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_B);
  // driven lanes per link mode, unknown modes drive nothing
  function automatic logic [15:0] oe_of(input logic [7:0] m);
    case (m)
      8'h1b: return 16'hffff;
      8'h20, 8'h21: return 16'h0707;
      8'h22, 8'h23, 8'h25: return 16'h0303;
      8'h26, 8'h27, 8'h38: return 16'h0101;
      default: return 16'h0000;
    endcase
  endfunction : oe_of
  AST_FEC_MIRROR: assert property (1'b1 |=> sync_fec == $past(fec_sel))
    else $error("sync_fec lags fec_sel wrongly");
  AST_CRC_IN_FEC: assert property (fec_sel[*3] |-> sync_crc == 12'h000)
    else $error("crc runs while fec chosen");
  AST_PIN_OFF: assert property (power_down_pin[*7] |-> lane_oe == 16'h0000 && !frame_strobe)
    else $error("lanes active with pin down");
  AST_CFG_PD_OFF: assert property (mode_pd[*3] |-> lane_oe == 16'h0000 && !frame_strobe)
    else $error("lanes active in config down");
  AST_CHAN_A_OFF: assert property (
    (chan_pd[0] && link_mode_select == 8'h38)[*2] |-> lane_oe[7:0] == 8'h00)
    else $error("channel A lanes on while powered off");
  // the wait covers the pin synchroniser plus one edge
  AST_OE_BY_MODE: assert property (
    (!mode_pd && !power_down_pin && chan_pd == 2'h0 && $stable(link_mode_select))[*8]
    |-> lane_oe == oe_of(link_mode_select))
    else $error("lane enables do not match mode");
  AST_MODE38_WORD: assert property (
    frame_strobe && $past(link_mode_select) == 8'h26 && $past(test_pattern_select) == 4'h0
    |-> lane_data[0][15:0] == 16'h0000 && lane_data[8][15:0] == 16'h0000)
    else $error("mode 38 word misplaced");
  AST_CLOCK_PAT: assert property (
    frame_strobe && $past(test_pattern_select) == 4'h1 |-> lane_data[0] == lane_map_pkg::CLOCK_PAT)
    else $error("clock pattern wrong");
  AST_RAMP_OCTETS: assert property (
    frame_strobe && $past(test_pattern_select) == 4'h2 |-> lane_data[0][23:16] == lane_data[0][31:24] + 8'h01)
    else $error("ramp octets not consecutive");
  cover property (frame_strobe && link_mode_select == 8'h1b);
  cover property (power_down_pin[*7]);
  cover property (frame_strobe && test_pattern_select == 4'h2);
endmodule : lane_map_assertions
`default_nettype wire

// [tb/tb_jesd_lane_mapper_test_ctrl.sv]
`default_nettype none
module tb_jesd_lane_mapper_test_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  // stimulus and observed signals
  logic             MCLK, RST_B, SMP_VALID, IRQ, RX_VALID;
  logic [7:0][14:0] SMP_A, SMP_B;
  logic [7:0]       FLG_A, FLG_B, AWADDR, ARADDR;
  logic             AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic             ARVALID, ARREADY, RVALID, RREADY;
  logic [31:0]      WDATA, RDATA, RX_A0, RX_B0;
  logic [3:0]       WSTRB;
  logic [1:0]       BRESP, RRESP;
  int               n_fail, cmp_count;
  lane_map_if       link ();
  lane_mapper i_lane_mapper (.MCLK, .RST_B, .SMP_A, .SMP_B, .FLG_A, .FLG_B, .SMP_VALID, .LINK(link));
  link_ctrl i_link_ctrl (.MCLK, .RST_B, .AWVALID, .AWREADY, .AWADDR, .WVALID, .WREADY, .WDATA, .WSTRB,
    .BVALID, .BREADY, .BRESP, .ARVALID, .ARREADY, .ARADDR, .RVALID, .RREADY, .RDATA, .RRESP,
    .IRQ, .RX_VALID, .RX_A0, .RX_B0, .LINK(link));
  lane_map_assertions i_lane_map_assertions (.MCLK, .RST_B, .fec_sel(link.fec_sel), .mode_pd(link.mode_pd),
    .power_down_pin(link.power_down_pin), .chan_pd(link.chan_pd), .link_mode_select(link.link_mode_select),
    .test_pattern_select(link.test_pattern_select), .lane_data(link.lane_data), .lane_oe(link.lane_oe),
    .frame_strobe(link.frame_strobe), .sync_crc(link.sync_crc), .sync_fec(link.sync_fec));
  // 100 MHz clock
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  task automatic wrap_up;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] g, e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  // bus tasks read handshakes right after the edge, before it lands
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    @(posedge MCLK);
    {AWADDR, WDATA} <= {a, d};
    {AWVALID, WVALID, BREADY} <= 3'h7;
    n = 0;
    do begin
      @(posedge MCLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      n++;
    end while (!BVALID && n < 40);
    BREADY <= 1'b0;
    chk(32'(BVALID), 32'h1);
    chk(32'(BRESP), 32'(r));
    if (!BVALID) wrap_up();
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] r);
    int n;
    @(posedge MCLK);
    ARADDR <= a;
    {ARVALID, RREADY} <= 2'h3;
    n = 0;
    do begin
      @(posedge MCLK);
      if (ARREADY) ARVALID <= 1'b0;
      n++;
    end while (!RVALID && n < 40);
    RREADY <= 1'b0;
    chk(32'(RVALID), 32'h1);
    chk(RDATA & m, e);
    chk(32'(RRESP), 32'(r));
    if (!RVALID) wrap_up();
  endtask : rdc
  // words on lanes A0 and B0 seen by the host per mode
  function automatic logic [63:0] expw(input logic [7:0] m);
    case (m)
      8'h20, 8'h21: return {SMP_A[0][14:3], SMP_A[1][14:11], 16'h0, SMP_B[0][14:3], SMP_B[1][14:11], 16'h0};
      8'h22, 8'h23: return {SMP_A[0][14:7], 24'h0, SMP_B[0][14:7], 24'h0};
      8'h27, 8'h38: return {SMP_A[0], FLG_A[0], SMP_A[1], FLG_A[1], SMP_B[0], FLG_B[0], SMP_B[1], FLG_B[1]};
      default: return {SMP_A[0], FLG_A[0], 16'h0, SMP_B[0], FLG_B[0], 16'h0};
    endcase
  endfunction : expw
  // word on lane A1 per mode; lanes a mode leaves off read zero
  function automatic logic [31:0] expa1(input logic [7:0] m);
    case (m)
      8'h1b, 8'h25: return {SMP_A[1], FLG_A[1], 16'h0};
      8'h20, 8'h21: return {SMP_A[1][10:3], SMP_A[2][14:7], 16'h0};
      8'h22, 8'h23: return {SMP_A[1][14:7], 24'h0};
      default: return 32'h0;
    endcase
  endfunction : expa1
  task automatic frm(input logic [63:0] e, input logic v);
    int n;
    @(posedge MCLK);
    SMP_VALID <= 1'b1;
    @(posedge MCLK);
    SMP_VALID <= 1'b0;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (!RX_VALID && n < 20);
    chk(32'(RX_VALID), 32'(v));
    if (v) begin
      chk(RX_A0, e[63:32]);
      chk(RX_B0, e[31:0]);
    end
    if (v && !RX_VALID) wrap_up();
  endtask : frm
  task automatic t_reset;
    rdc(8'h08, 32'hfff, 32'h026, 2'b00);
    rdc(8'h04, 32'h3, 32'h1, 2'b00);
    chk(32'(link.converter_off), 32'h1);
    rdc(8'h40, 32'hffffffff, 32'h0, 2'b10);
    wr(8'h0c, 32'h0, 2'b10);
  endtask : t_reset
  // mode is changed only with the link stopped
  task automatic t_modes;
    logic [7:0] md [9] = '{8'h1b, 8'h20, 8'h21, 8'h22, 8'h23, 8'h25, 8'h26, 8'h27, 8'h38};
    foreach (md[i]) begin
      wr(8'h00, 32'h0, 2'b00);
      wr(8'h08, {24'h0, md[i]}, 2'b00);
      wr(8'h00, 32'h1, 2'b00);
      frm(expw(md[i]), 1'b1);
      chk(link.lane_data[1], expa1(md[i]));
    end
    // channel A off in a dual mode: lane A0 drops, lane B0 still carries
    wr(8'h00, 32'h11, 2'b00);
    frm(expw(8'h38) & 64'h00000000ffffffff, 1'b1);
  endtask : t_modes
  task automatic t_irq;
    chk(32'(IRQ), 32'h0);
    wr(8'h10, 32'h1, 2'b00);
    repeat (3) @(posedge MCLK);
    chk(32'(IRQ), 32'h1);
    rdc(8'h0c, 32'h1, 32'h1, 2'b00);
    repeat (3) @(posedge MCLK);
    chk(32'(IRQ), 32'h0);
  endtask : t_irq
  task automatic t_refuse;
    wr(8'h08, 32'h138, 2'b00);
    rdc(8'h08, 32'hfff, 32'h038, 2'b00);
    rdc(8'h0c, 32'h4, 32'h4, 2'b00);
    wr(8'h00, 32'h3, 2'b00);
    repeat (4) @(posedge MCLK);
    rdc(8'h1c, 32'h10fff, 32'h10000, 2'b00);
  endtask : t_refuse
  task automatic t_test;
    wr(8'h00, 32'h0, 2'b00);
    wr(8'h08, 32'h126, 2'b00);
    wr(8'h00, 32'h1, 2'b00);
    frm({2{lane_map_pkg::CLOCK_PAT}}, 1'b1);
    wr(8'h00, 32'h0, 2'b00);
    wr(8'h08, 32'h226, 2'b00);
    wr(8'h00, 32'h1, 2'b00);
    repeat (6) @(posedge MCLK);
    chk(32'(8'(RX_A0[23:16] - RX_A0[31:24])), 32'h1);
    wr(8'h00, 32'h0, 2'b00);
    wr(8'h08, 32'h026, 2'b00);
  endtask : t_test
  // pin then config power-down, each followed by the flush wait
  task automatic t_pd;
    logic [31:0] pd [2] = '{32'h9, 32'h5};
    foreach (pd[i]) begin
      wr(8'h00, pd[i], 2'b00);
      repeat (8) @(posedge MCLK);
      frm(64'h0, 1'b0);
      wr(8'h00, 32'h1, 2'b00);
      repeat (110) @(posedge MCLK);
      rdc(8'h0c, 32'h2, 32'h2, 2'b00);
      frm(expw(8'h26), 1'b1);
    end
  endtask : t_pd
  // main sequence
  initial begin
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, SMP_VALID, RST_B} = 7'h0;
    {AWADDR, ARADDR, WDATA} = 48'h0;
    WSTRB = 4'hf;
    SMP_A = 120'h123456789abcdef0123456789abcde;
    SMP_B = 120'hfedcba9876543210fedcba98765432;
    FLG_A = 8'ha5;
    FLG_B = 8'h3c;
    n_fail = 0;
    cmp_count = 0;
    repeat (12) @(posedge MCLK);
    RST_B <= 1'b1;
    t_reset();
    t_modes();
    t_irq();
    t_refuse();
    t_test();
    t_pd();
    wrap_up();
  end
endmodule : tb_jesd_lane_mapper_test_ctrl
`default_nettype wire
